// [src/cantc_pkg.sv]
// package of the receive-fifo, error and bit-timing status block.
// assumes an apb master on pclk and a protocol core on the same clock.
package cantc_pkg;
	// ****************************************************************
	// register map (byte addresses)
	// ****************************************************************
	localparam logic [7:0] A_FIFO0 = 8'h00;
	localparam logic [7:0] A_FIFO1 = 8'h04;
	localparam logic [7:0] A_IE    = 8'h08;
	localparam logic [7:0] A_ESR   = 8'h0C;
	localparam logic [7:0] A_EIER  = 8'h10;
	localparam logic [7:0] A_TEC   = 8'h14;
	localparam logic [7:0] A_REC   = 8'h18;
	localparam logic [7:0] A_DIAG  = 8'h1C;
	localparam logic [7:0] A_BT0   = 8'h20;
	localparam logic [7:0] A_BT1   = 8'h24;
	localparam logic [7:0] A_STAT  = 8'h28;
	// ****************************************************************
	// fields, resets and limits
	// ****************************************************************
	localparam int F_REL  = 5;
	localparam int F_OVR  = 4;
	localparam int F_FULL = 3;
	localparam int F_WAKE = 3;
	localparam int F_ERROR_SUMMARY_FLAG = 2;
	localparam logic [7:0] EIER_MASK = 8'h97;
	localparam logic [7:0] BT0_RST   = 8'h00;
	localparam logic [6:0] BT1_RST   = 7'h23;
	localparam logic [1:0] FIFO_MAX  = 2'h3;
	localparam logic [8:0] TEC_OFF   = 9'h0FF;
	localparam logic [7:0] PASS_LIM  = 8'h7F;
	localparam logic [7:0] WARN_LIM  = 8'h60;
	localparam logic [7:0] REC_HIGH  = 8'h80;
	localparam logic [7:0] REC_LOAD  = 8'h78;
	localparam logic [2:0] LEC_SW    = 3'h7;
	// ****************************************************************
	// carriers
	// ****************************************************************
	typedef struct packed {
		logic store;
		logic rel_set;
		logic ovr_clr;
		logic full_clr;
	} cantc_fctl_t;
	typedef struct packed {
		logic pend;
		logic full;
		logic ovr;
	} cantc_fen_t;
	typedef struct packed {
		logic [1:0] store;
		logic       err_evt;
		logic [2:0] err_code;
		logic       rx_good;
		logic       tx_good;
		logic       rx_err1;
		logic       rx_err8;
		logic       tx_err8;
		logic [2:0] req_done;
		logic       wake_evt;
		logic       sample_bit;
	} cantc_core_t;
	typedef struct packed {
		logic [1:0] cnt;
		logic       ovr;
		logic       full;
		logic       rel;
		logic       irq;
	} cantc_fifo_t;
endpackage : cantc_pkg

// [src/cantc_fifo_stat.sv]
// status of one receive fifo: pending count, flags, release, interrupt.
// assumes store and control pulses on pclk from the parent block.
`timescale 1ns/100ps
module cantc_fifo_stat
	import cantc_pkg::*;
(
	// clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        ce,
	// control
	input  wire cantc_fctl_t ctl,
	input  wire cantc_fen_t  en,
	// status
	output logic [7:0]       stat,
	output logic             rel_done,
	output logic             irq
);
	cantc_fifo_t s, n;
	logic        room;
	always_comb begin
		n = s;
		n.irq = 1'b0;
		room = (s.cnt != FIFO_MAX) || s.rel;
		if (s.rel) begin
			n.rel = 1'b0;
		end else if (ctl.rel_set && s.cnt != 2'h0) begin
			n.rel = 1'b1;
		end
		n.cnt = s.cnt + {1'b0, ctl.store && room}
			- {1'b0, s.rel};
		if (ctl.ovr_clr) begin
			n.ovr = 1'b0;
		end
		if (ctl.full_clr) begin
			n.full = 1'b0;
		end
		if (ctl.store && !room) begin
			n.ovr = 1'b1;
		end
		if (n.cnt == FIFO_MAX && s.cnt != FIFO_MAX) begin
			n.full = 1'b1;
		end
		n.irq = (en.pend && s.cnt == 2'h0 && n.cnt == 2'h1)
			|| (en.full && n.full && !s.full)
			|| (en.ovr && n.ovr && !s.ovr);
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s <= '0;
		end else if (ce) begin
			s <= n;
		end
	end
	assign stat     = {2'h0, s.rel, s.ovr, s.full, 1'b0, s.cnt};
	assign rel_done = s.rel;
	assign irq      = s.irq;
	// ****************************************************************
	// checks
	// ****************************************************************
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	a_rel_empty: assert property (ce && ctl.rel_set && s.cnt == 2'h0
		&& !s.rel |=> !s.rel && s.cnt == 2'h0)
		else $error("release taken on empty fifo");
	a_ovr_set: assert property (ce && ctl.store
		&& s.cnt == FIFO_MAX && !s.rel |=> s.ovr && s.cnt == FIFO_MAX)
		else $error("overrun not flagged");
	a_full_set: assert property (ce && ctl.store && !s.rel
		&& s.cnt == 2'h2 |=> s.full)
		else $error("full not flagged at three");
	a_cnt_step: assert property (ce && ctl.store && !s.rel
		&& s.cnt != FIFO_MAX |=> s.cnt == $past(s.cnt) + 2'h1)
		else $error("pending count did not rise");
	a_w1c_keep: assert property (ce && s.ovr && !ctl.ovr_clr
		|=> s.ovr)
		else $error("overrun flag lost");
	a_pend_irq: assert property (ce && en.pend && ctl.store
		&& s.cnt == 2'h0 |=> irq ##1 !irq)
		else $error("pending interrupt missing");
	c_overrun: cover property (ce && ctl.store && !room);
	c_release: cover property (s.rel ##1 s.cnt != 2'h0);
endmodule : cantc_fifo_stat

// [src/cantc_regs.sv]
// apb register block: fifo status, interrupt enables, error state,
// error counters, diagnosis and bit timing.
// assumes a protocol core on pclk that pulses events for one cycle.
`timescale 1ns/100ps
module cantc_regs
	import cantc_pkg::*;
(
	// clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        ce,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	// protocol core
	input  wire cantc_core_t core,
	input  wire logic        config_mode,
	input  wire logic        can_rx,
	// controls to the core
	output logic [1:0]       release_pulse,
	output logic             bus_off_flag,
	output logic             err_passive_flag,
	output logic             listen_only_mode,
	output logic             internal_loop_mode,
	output logic [1:0]       resync_jump_width,
	output logic [5:0]       quantum_prescaler,
	output logic [3:0]       segment_one_len,
	output logic [2:0]       segment_two_len,
	output logic             tq_tick,
	// interrupt requests
	output logic             irq_tx,
	output logic [1:0]       irq_fifo,
	output logic             irq_status
);
	// ****************************************************************
	// state
	// ****************************************************************
	typedef struct packed {
		logic [7:0]  ie;
		logic [2:0]  last_error_kind;
		logic        bus_off;
		logic        passive;
		logic        warning;
		logic [7:0]  eier;
		logic [8:0]  tx_fault_counter;
		logic [7:0]  rx_fault_counter;
		logic        listen;
		logic        loop;
		logic [7:0]  bt0;
		logic [6:0]  bt1;
		logic        wake_flag;
		logic        error_summary_flag;
		logic        rx_s1;
		logic        rx_s2;
		logic        last_sample_bit;
		logic [31:0] prdata;
		logic        tx_irq;
		logic [5:0]  tq_cnt;
		logic        tq_tick;
	} cantc_state_t;

	cantc_state_t s, n;
	cantc_fctl_t  fctl [2];
	cantc_fen_t   fen [2];
	logic [7:0]   fstat [2];
	logic [1:0]   frel;
	logic [1:0]   firq;
	logic         setup;
	logic         wr;
	logic         hit;
	logic [7:0]   rd;
	logic [7:0]   esr;
	logic [9:0]   tec_sum;
	logic [8:0]   rec_sum;
	logic         good;
	logic         err_hw;

	assign setup = psel && !penable;
	assign wr    = psel && penable && pwrite && ce;
	assign esr   = {1'b0, s.last_error_kind, 1'b0,
		s.bus_off, s.passive, s.warning};
	assign good   = core.rx_good || core.tx_good;
	assign err_hw = core.err_evt && core.err_code != 3'h0
		&& core.err_code != LEC_SW;

	// ****************************************************************
	// address decode and read mux
	// ****************************************************************
	always_comb begin
		hit = 1'b1;
		rd  = 8'h00;
		unique case (paddr)
			A_FIFO0: rd = fstat[0];
			A_FIFO1: rd = fstat[1];
			A_IE:    rd = s.ie;
			A_ESR:   rd = esr;
			A_EIER:  rd = s.eier;
			A_TEC:   rd = s.tx_fault_counter[7:0];
			A_REC:   rd = s.rx_fault_counter;
			A_DIAG:  rd = {4'h0, s.rx_s2, s.last_sample_bit,
				s.listen, s.loop};
			A_BT0:   rd = s.bt0;
			A_BT1:   rd = {1'b0, s.bt1};
			A_STAT:  rd = {4'h0, s.wake_flag,
				s.error_summary_flag, 2'h0};
			default: hit = 1'b0;
		endcase
	end

	// ****************************************************************
	// receive fifos
	// ****************************************************************
	always_comb begin
		for (int i = 0; i < 2; i++) begin
			fctl[i].store    = core.store[i];
			fctl[i].rel_set  = 1'b0;
			fctl[i].ovr_clr  = 1'b0;
			fctl[i].full_clr = 1'b0;
			if (wr && paddr == (i == 0 ? A_FIFO0 : A_FIFO1)) begin
				fctl[i].rel_set  = pwdata[F_REL];
				fctl[i].ovr_clr  = pwdata[F_OVR];
				fctl[i].full_clr = pwdata[F_FULL];
			end
		end
		fen[0] = '{pend: s.ie[1], full: s.ie[2], ovr: s.ie[3]};
		fen[1] = '{pend: s.ie[4], full: s.ie[5], ovr: s.ie[6]};
	end

	for (genvar g = 0; g < 2; g++) begin : g_fifo
		cantc_fifo_stat u_fifo (
			.pclk     (pclk),
			.presetn  (presetn),
			.ce       (ce),
			.ctl      (fctl[g]),
			.en       (fen[g]),
			.stat     (fstat[g]),
			.rel_done (frel[g]),
			.irq      (firq[g])
		);
	end

	// ****************************************************************
	// next state
	// ****************************************************************
	always_comb begin
		n = s;
		tec_sum = {1'b0, s.tx_fault_counter};
		rec_sum = {1'b0, s.rx_fault_counter};
		n.rx_s1 = can_rx;
		n.rx_s2 = s.rx_s1;
		n.last_sample_bit  = core.sample_bit;
		if (setup) begin
			n.prdata = {24'h0, rd};
		end
		// software writes
		if (wr) begin
			unique case (paddr)
				A_IE:   n.ie = pwdata[7:0];
				A_ESR:  n.last_error_kind = pwdata[6:4];
				A_EIER: n.eier = pwdata[7:0] & EIER_MASK;
				A_DIAG: begin
					n.listen = pwdata[1];
					n.loop   = pwdata[0];
				end
				A_BT0: begin
					if (config_mode) begin
						n.bt0 = pwdata[7:0];
					end
				end
				A_BT1:  n.bt1 = pwdata[6:0];
				A_STAT: begin
					if (pwdata[F_WAKE]) begin
						n.wake_flag = 1'b0;
					end
					if (pwdata[F_ERROR_SUMMARY_FLAG]) begin
						n.error_summary_flag = 1'b0;
					end
				end
				default: ;
			endcase
		end
		// last error field, hardware wins over software
		if (good) begin
			n.last_error_kind = 3'h0;
		end
		if (err_hw) begin
			n.last_error_kind = core.err_code;
		end
		// transmit error counter, saturating at nine bits
		if (core.tx_err8) begin
			tec_sum = tec_sum + 10'h008;
		end else if (core.tx_good && tec_sum != 10'h000) begin
			tec_sum = tec_sum - 10'h001;
		end
		n.tx_fault_counter = tec_sum[9] ? 9'h1FF : tec_sum[8:0];
		// receive error counter
		if (core.rx_err8) begin
			rec_sum = rec_sum + 9'h008;
		end else if (core.rx_err1) begin
			rec_sum = rec_sum + 9'h001;
		end else if (core.rx_good) begin
			if (s.rx_fault_counter > REC_HIGH) begin
				rec_sum = {1'b0, REC_LOAD};
			end else if (rec_sum != 9'h000) begin
				rec_sum = rec_sum - 9'h001;
			end
		end
		n.rx_fault_counter = rec_sum[8] ? 8'hFF : rec_sum[7:0];
		// error state flags follow the counters
		n.bus_off = n.tx_fault_counter > TEC_OFF;
		n.passive = n.tx_fault_counter > {1'b0, PASS_LIM}
			|| n.rx_fault_counter > PASS_LIM;
		n.warning = n.tx_fault_counter > {1'b0, WARN_LIM}
			|| n.rx_fault_counter > WARN_LIM;
		// summary flag, set wins over clear
		if ((err_hw && s.eier[4])
			|| (n.bus_off && !s.bus_off && s.eier[2])
			|| (n.passive && !s.passive && s.eier[1])
			|| (n.warning && !s.warning && s.eier[0])) begin
			n.error_summary_flag = 1'b1;
		end
		if (core.wake_evt) begin
			n.wake_flag = 1'b1;
		end
		n.tx_irq = s.ie[0] && core.req_done != 3'h0;
		// time quantum divider
		n.tq_tick = 1'b0;
		if (s.tq_cnt >= s.bt0[5:0]) begin
			n.tq_cnt  = 6'h00;
			n.tq_tick = 1'b1;
		end else begin
			n.tq_cnt = s.tq_cnt + 6'h01;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s     <= '0;
			s.bt0 <= BT0_RST;
			s.bt1 <= BT1_RST;
		end else if (ce) begin
			s <= n;
		end
	end

	// ****************************************************************
	// outputs
	// ****************************************************************
	assign prdata             = s.prdata;
	assign pready             = ce;
	assign pslverr            = psel && penable && !hit;
	assign release_pulse      = frel;
	assign bus_off_flag       = s.bus_off;
	assign err_passive_flag   = s.passive;
	assign listen_only_mode   = s.listen;
	assign internal_loop_mode = s.loop;
	assign resync_jump_width  = s.bt0[7:6];
	assign quantum_prescaler  = s.bt0[5:0];
	assign segment_one_len    = s.bt1[3:0];
	assign segment_two_len    = s.bt1[6:4];
	assign tq_tick            = s.tq_tick;
	assign irq_tx             = s.tx_irq;
	assign irq_fifo           = firq;
	assign irq_status         = (s.ie[7] && s.wake_flag)
		|| (s.eier[7] && s.error_summary_flag);

	// ****************************************************************
	// checks
	// ****************************************************************
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	a_bt0_locked: assert property (ce && wr && paddr == A_BT0
		&& !config_mode |=> $stable(s.bt0))
		else $error("bit timing changed outside config");
	a_lec_code: assert property (ce && err_hw
		|=> s.last_error_kind == $past(core.err_code))
		else $error("last error code not stored");
	a_lec_clear: assert property (ce && good && !core.err_evt
		&& !wr |=> s.last_error_kind == 3'h0)
		else $error("last error code not cleared");
	a_bus_off: assert property (bus_off_flag
		== (s.tx_fault_counter > TEC_OFF))
		else $error("bus off flag wrong");
	a_passive: assert property (err_passive_flag
		== (s.tx_fault_counter > 9'h07F || s.rx_fault_counter > 8'h7F))
		else $error("passive flag wrong");
	a_warning: assert property (s.warning
		== (s.tx_fault_counter > 9'h060 || s.rx_fault_counter > 8'h60))
		else $error("warning flag wrong");
	a_rec_load: assert property (ce && core.rx_good && !core.rx_err1
		&& !core.rx_err8 && s.rx_fault_counter > 8'h80
		|=> s.rx_fault_counter == 8'h78)
		else $error("receive counter not reloaded");
	a_error_summary_flag_set: assert property (ce && err_hw && s.eier[4]
		|=> s.error_summary_flag)
		else $error("summary flag not set");
	a_status_irq: assert property (s.error_summary_flag
		&& s.eier[7] |-> irq_status)
		else $error("status interrupt missing");
	a_tx_irq: assert property (ce && s.ie[0]
		&& core.req_done != 3'h0 |=> irq_tx)
		else $error("tx interrupt missing");
	// interrupts, software fields, counters, pin and quantum tick
	a_wake_irq: assert property (s.ie[7] && s.wake_flag
		|-> irq_status)
		else $error("wake interrupt missing");
	a_tx_irq_off: assert property (ce && !s.ie[0]
		|=> !irq_tx)
		else $error("tx interrupt while disabled");
	a_lec_sw: assert property (ce && wr && paddr == A_ESR && !good
		&& !err_hw |=> s.last_error_kind == $past(pwdata[6:4]))
		else $error("last error write lost");
	a_rec_dec: assert property (ce && core.rx_good && !core.rx_err1
		&& !core.rx_err8 && s.rx_fault_counter <= 8'h80
		&& s.rx_fault_counter != 8'h00
		|=> s.rx_fault_counter == $past(s.rx_fault_counter) - 8'h01)
		else $error("receive counter not decremented");
	a_rx_sync: assert property (ce |=> s.rx_s2 == $past(s.rx_s1))
		else $error("receive pin sync broken");
	a_loop_mode: assert property (ce && wr && paddr == A_DIAG
		|=> internal_loop_mode == $past(pwdata[0]))
		else $error("loopback bit not written");
	a_listen_mode: assert property (ce && wr && paddr == A_DIAG
		|=> listen_only_mode == $past(pwdata[1]))
		else $error("silent bit not written");
	a_seg_two: assert property (ce && wr && paddr == A_BT1
		|=> segment_two_len == $past(pwdata[6:4]))
		else $error("segment two not written");
	a_tq_tick: assert property (ce && s.tq_cnt >= s.bt0[5:0]
		|=> tq_tick)
		else $error("quantum tick missing");
	a_tq_quiet: assert property (ce && s.tq_cnt < s.bt0[5:0]
		|=> !tq_tick)
		else $error("quantum tick early");
	c_bus_off: cover property ($rose(s.bus_off));
	c_error_summary_flag_irq: cover property ($rose(irq_status));
	c_bt0_write: cover property (wr && paddr == A_BT0 && config_mode);
endmodule : cantc_regs

// [bench/cantc_core_model.sv]
// far side of the status block: protocol core and the bus receive pin.
// assumes the bench calls its tasks from a process on pclk.
`timescale 1ns/100ps
module cantc_core_model
	import cantc_pkg::*;
(
	// clock
	input  wire logic pclk,
	// towards the block
	output cantc_core_t core,
	output logic        can_rx
);
	initial begin
		core = '0;
		can_rx = 1'b1;
	end

	// one-cycle event pulse; the sample bit is a level and survives it
	task automatic ev(input cantc_core_t e);
		@(posedge pclk);
		core <= e;
		@(posedge pclk);
		core <= cantc_core_t'{sample_bit: e.sample_bit, default: 0};
	endtask : ev

	// receive pin level, changed off the register update
	task automatic pin(input logic v);
		@(posedge pclk);
		can_rx <= v;
	endtask : pin
endmodule : cantc_core_model

// [bench/can_rx_fifo_error_timing_ctrl_tb.sv]
// testbench of the status block: apb master, event counters, verdict.
// assumes the core model as far side; the bench drives the clock enable.
`timescale 1ns/100ps
module can_rx_fifo_error_timing_ctrl_tb
	import cantc_pkg::*;
;
	logic        pclk, presetn, psel, penable, pwrite, config_mode;
	logic        pready, pslverr, can_rx, bus_off_flag, err_passive_flag;
	logic        listen_only_mode, internal_loop_mode, tq_tick, irq_tx;
	logic        irq_status, er, ce;
	logic [7:0]  paddr, fa;
	logic [31:0] pwdata, prdata, rd;
	logic [1:0]  release_pulse, resync_jump_width, irq_fifo;
	logic [5:0]  quantum_prescaler;
	logic [3:0]  segment_one_len;
	logic [2:0]  segment_two_len;
	cantc_core_t core;
	int          miscompares, total_checks, ntx, n;
	int          nirq[2], nrel[2];

	cantc_regs i_dut (.pclk, .presetn, .ce, .psel, .penable, .pwrite,
		.paddr, .pwdata, .prdata, .pready, .pslverr, .core, .config_mode,
		.can_rx, .release_pulse, .bus_off_flag, .err_passive_flag,
		.listen_only_mode, .internal_loop_mode, .resync_jump_width,
		.quantum_prescaler, .segment_one_len, .segment_two_len, .tq_tick,
		.irq_tx, .irq_fifo, .irq_status);
	cantc_core_model i_core (.pclk, .core, .can_rx);

	// ********
	// clock, pulse counters, watchdog
	// ********
	initial begin
		pclk = 1'b0;
		forever #10 pclk = ~pclk;
	end
	always @(posedge pclk) begin
		for (int q = 0; q < 2; q++) begin
			nirq[q] += (irq_fifo[q] === 1'b1);
			nrel[q] += (release_pulse[q] === 1'b1);
		end
		ntx += (irq_tx === 1'b1);
	end
	initial begin
		repeat (20000) @(posedge pclk);
		miscompares++;
		print_verdict;
	end

	// ********
	// tasks
	// ********
	task automatic chk(input string s, input logic [31:0] e, g);
		total_checks++;
		if (g !== e) begin
			miscompares++;
			$display("MISMATCH %s expected %h seen %h", s, e, g);
		end
	endtask : chk

	task automatic apb(input logic w, input logic [7:0] a, d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h00_0000, d};
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic rc(input logic [7:0] a, e, input string s);
		apb(1'b0, a, 8'h00);
		chk(s, {24'h00_0000, e}, rd);
	endtask : rc

	task automatic print_verdict;
		$display("checks %0d miscompares %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : print_verdict

	// ********
	// tests
	// ********
	initial begin
		{presetn, psel, penable, pwrite, config_mode} = '0;
		ce = 1'b1;
		{paddr, pwdata} = '0;
		{miscompares, total_checks, ntx} = '0;
		nirq = '{0, 0};
		nrel = '{0, 0};
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		rc(A_FIFO0, 8'h00, "fifo0 rst");
		rc(A_IE, 8'h00, "ie rst");
		rc(A_ESR, 8'h00, "esr rst");
		rc(A_TEC, 8'h00, "tec rst");
		rc(A_DIAG, 8'h08, "diag rst");
		rc(A_BT1, 8'h23, "bt1 rst");
		apb(1'b1, A_TEC, 8'hFF);
		rc(A_TEC, 8'h00, "tec ro");
		rc(8'h2C, 8'h00, "unmapped");
		chk("slverr", 1, er);
		apb(1'b1, A_IE, 8'h7E);
		for (int q = 0; q < 2; q++) begin
			fa = q ? A_FIFO1 : A_FIFO0;
			repeat (4) i_core.ev(cantc_core_t'{store: 2'(1 << q), default: 0});
			rc(fa, 8'h1B, "full ovr");
			chk("fifo irqs", 3, nirq[q]);
			apb(1'b1, fa, 8'h00);
			rc(fa, 8'h1B, "w0 keeps");
			apb(1'b1, fa, 8'h18);
			rc(fa, 8'h03, "w1 clears");
			repeat (4) apb(1'b1, fa, 8'h20);
			rc(fa, 8'h00, "released");
			chk("releases", 3, nrel[q]);
			i_core.ev(cantc_core_t'{store: 2'(1 << q), default: 0});
			rc(fa, 8'h01, "one pending");
			chk("pend irq", 4, nirq[q]);
		end
		apb(1'b1, A_IE, 8'h01);
		i_core.ev(cantc_core_t'{req_done: 3'h4, default: 0});
		apb(1'b1, A_IE, 8'h80);
		i_core.ev(cantc_core_t'{req_done: 3'h1, default: 0});
		chk("tx irq", 1, ntx);
		i_core.ev(cantc_core_t'{wake_evt: 1'b1, default: 0});
		rc(A_STAT, 8'h08, "wake");
		chk("wake irq", 1, irq_status);
		apb(1'b1, A_STAT, 8'h08);
		rc(A_STAT, 8'h00, "wake clr");
		chk("wake irq clr", 0, irq_status);
		apb(1'b1, A_EIER, 8'h81);
		repeat (12) i_core.ev(cantc_core_t'{rx_err8: 1'b1, default: 0});
		rc(A_REC, 8'h60, "rec 96");
		rc(A_ESR, 8'h00, "no warning");
		i_core.ev(cantc_core_t'{rx_err1: 1'b1, default: 0});
		rc(A_ESR, 8'h01, "warning");
		rc(A_STAT, 8'h04, "summary");
		chk("err irq", 1, irq_status);
		apb(1'b1, A_STAT, 8'h04);
		repeat (4) i_core.ev(cantc_core_t'{rx_err8: 1'b1, default: 0});
		rc(A_ESR, 8'h03, "passive");
		chk("passive pin", 1, err_passive_flag);
		rc(A_STAT, 8'h00, "passive gated");
		chk("err irq off", 0, irq_status);
		i_core.ev(cantc_core_t'{rx_good: 1'b1, default: 0});
		rc(A_REC, 8'h78, "rec load");
		i_core.ev(cantc_core_t'{rx_good: 1'b1, default: 0});
		rc(A_REC, 8'h77, "rec dec");
		apb(1'b1, A_EIER, 8'h84);
		repeat (31) i_core.ev(cantc_core_t'{tx_err8: 1'b1, default: 0});
		rc(A_ESR, 8'h03, "tec 248");
		chk("not off", 0, bus_off_flag);
		i_core.ev(cantc_core_t'{tx_err8: 1'b1, default: 0});
		rc(A_ESR, 8'h07, "bus off");
		chk("off pin", 1, bus_off_flag);
		rc(A_TEC, 8'h00, "tec low byte");
		rc(A_STAT, 8'h04, "off summary");
		apb(1'b1, A_STAT, 8'h04);
		apb(1'b1, A_EIER, 8'h90);
		for (int k = 1; k < 7; k++) begin
			i_core.ev(cantc_core_t'{err_evt: 1'b1, err_code: 3'(k), default: 0});
			rc(A_ESR, 8'h07 | 8'(k << 4), "lec");
		end
		rc(A_STAT, 8'h04, "lec summary");
		i_core.ev(cantc_core_t'{tx_good: 1'b1, default: 0});
		rc(A_ESR, 8'h03, "lec cleared");
		apb(1'b1, A_ESR, 8'h70);
		rc(A_ESR, 8'h73, "lec sw 7");
		apb(1'b1, A_BT0, 8'h45);
		rc(A_BT0, 8'h00, "bt0 locked");
		config_mode <= 1'b1;
		apb(1'b1, A_BT0, 8'h45);
		rc(A_BT0, 8'h45, "bt0 written");
		chk("jump width", 1, resync_jump_width);
		chk("prescaler", 5, quantum_prescaler);
		for (n = 0; n < 99 && tq_tick !== 1'b1; n++) @(negedge pclk);
		for (n = 1; n < 99; n++) begin
			@(negedge pclk);
			if (tq_tick === 1'b1) break;
		end
		chk("quantum", 6, n);
		apb(1'b1, A_BT1, 8'hDA);
		rc(A_BT1, 8'h5A, "bt1");
		chk("seg one", 4'hA, segment_one_len);
		chk("seg two", 5, segment_two_len);
		apb(1'b1, A_DIAG, 8'h0F);
		i_core.pin(1'b0);
		i_core.ev(cantc_core_t'{sample_bit: 1'b1, default: 0});
		rc(A_DIAG, 8'h07, "diag");
		chk("modes", 3, {listen_only_mode, internal_loop_mode});
		// a store while the clock enable is low must be lost
		ce <= 1'b0;
		i_core.ev(cantc_core_t'{store: 2'h2, default: 0});
		chk("pready low", 0, pready);
		ce <= 1'b1;
		rc(A_FIFO1, 8'h01, "ce freeze");
		chk("pready high", 1, pready);
		print_verdict;
	end
endmodule : can_rx_fifo_error_timing_ctrl_tb
